// >>> src/lin_defs.vh
// register map, field positions, reset values and timing for the lin block
`ifndef LIN_DEFS_VH
`define LIN_DEFS_VH
`define OFS_DATA      6'h00
`define OFS_BAUD      6'h01
`define OFS_LINE      6'h02
`define OFS_LINCTL    6'h03
`define OFS_LINSTS    6'h04
`define OFS_FIFOSTS   6'h05
`define OFS_TOUT      6'h06
`define OFS_INTSTS    6'h07
`define OFS_INTEN     6'h08
`define OFS_INTCLR    6'h09
`define CTL_SEND      8
`define CTL_ID_PARITY_HW_ENABLE     9
`define CTL_BREAK_DETECT_ENABLE  10
`define CTL_BIT_ERROR_MONITOR_ENABLE  12
`define STS_BRKDET    8
`define FIFO_TXEMPTY  28
`define INT_RDA       0
`define INT_BITERR    1
`define INT_LIN       15
`define BAUD_RST      16'h0043
`define BREAK_LENGTH_RST     4'hb
`define BSL_RST       2'h0
`define DLY_RST       8'h00
`define LIN_FSEL      2'b01
`define SYNC_BYTE     8'h55
`define BRK_MIN_BITS  4'hb
`define BYTE_BITS     9'd10
`endif

// >>> src/lin_bit_timer.v
// bit-rate divider: one-cycle tick every div+1 clocks, restartable
`timescale 1ns/1ps
`default_nettype none
module lin_bit_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        en,
  input  wire        restart,
  input  wire [15:0] load,
  input  wire [15:0] div,
  output wire        tick
);
  reg [15:0] cnt_ff;

  assign tick = en & ~restart & (cnt_ff == 16'h0000);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
    end else if (restart) begin
      cnt_ff <= load;
    end else if (en) begin
      if (cnt_ff == 16'h0000) begin
        cnt_ff <= div;
      end else begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/lin_master_header_break_detect.v
// lin master: header generator, byte transmitter, break detector, apb regs
`timescale 1ns/1ps
`default_nettype none
`include "lin_defs.vh"
module lin_master_header_break_detect (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        rx_pin,
  output wire        tx_pin,
  output wire        irq
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_BRK  = 5'b00010;
  localparam [4:0] S_DLM  = 5'b00100;
  localparam [4:0] S_BYTE = 5'b01000;
  localparam [4:0] S_SPC  = 5'b10000;

  reg [31:0] prdata_ff;
  reg        pready_ff;
  reg        pslverr_ff;
  reg        tx_ff;
  reg        irq_ff;
  reg [15:0] div_ff;
  reg [5:0]  line_ff;
  reg        send_ff;
  reg        id_parity_hw_enable_ff;
  reg        brkdet_en_ff;
  reg        biterr_en_ff;
  reg [3:0]  break_length_ff;
  reg [1:0]  bsl_ff;
  reg [1:0]  hsel_ff;
  reg [7:0]  pid_ff;
  reg [7:0]  dly_ff;
  reg        brk_flag_ff;
  reg [2:0]  ists_ff;
  reg [2:0]  ien_ff;
  reg [7:0]  hold_ff;
  reg        hold_vld_ff;
  reg [7:0]  rx_data_ff;
  reg [4:0]  state_ff;
  reg [4:0]  nxt_state;
  reg [8:0]  cnt_ff;
  reg [9:0]  sh_ff;
  reg [9:0]  rxsh_ff;
  reg        hdr_ff;
  reg        sync_done_ff;
  reg        rx_meta_ff;
  reg        rx_s_ff;
  reg        rx_prev_ff;
  reg [3:0]  zcnt_ff;

  wire        wr_en = psel & penable & pready_ff & pwrite;
  wire        rd_en = psel & penable & pready_ff & ~pwrite;
  wire [5:0]  widx  = paddr[7:2];
  wire        lin_mode = (line_ff[5:4] == `LIN_FSEL);
  wire        is_idle  = state_ff[0];
  wire        tx_tick;
  wire        det_tick;
  wire        p0 = pid_ff[0] ^ pid_ff[1] ^ pid_ff[2] ^ pid_ff[4];
  wire        p1 = ~(pid_ff[1] ^ pid_ff[3] ^ pid_ff[4] ^ pid_ff[5]);
  wire [7:0]  id_byte = id_parity_hw_enable_ff ? {p1, p0, pid_ff[5:0]} : pid_ff;
  wire        last_bit = tx_tick & (cnt_ff == 9'd1);
  wire        start_hdr = is_idle & send_ff & lin_mode;
  wire        start_sw  = is_idle & ~send_ff & hold_vld_ff;
  wire        tx_empty  = is_idle & ~hold_vld_ff & ~send_ff;
  wire        det_fall  = brkdet_en_ff & rx_prev_ff & ~rx_s_ff
                          & (zcnt_ff == 4'h0);
  wire [15:0] rd_ists = {ists_ff[2], 13'h0000, ists_ff[1], ists_ff[0]};
  wire [15:0] rd_ien  = {ien_ff[2], 13'h0000, ien_ff[1], ien_ff[0]};
  wire        lin_set;
  wire        berr_set;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_pin  = tx_ff;
  assign irq     = irq_ff;

  // divider restarts at frame start so the first bit is a full bit
  lin_bit_timer u_tx_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (~is_idle),
    .restart (start_hdr | start_sw),
    .load    (div_ff),
    .div     (div_ff),
    .tick    (tx_tick)
  );

  // detector timer, realigned to mid-bit on a leading edge while zcnt_ff is zero
  lin_bit_timer u_det_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .en      (brkdet_en_ff),
    .restart (det_fall),
    .load    ({1'b0, div_ff[15:1]}),
    .div     (div_ff),
    .tick    (det_tick)
  );

  // rx pin synchroniser; rx_s_ff and rx_prev_ff are used by logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_ff <= 1'b1;
      rx_s_ff    <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rx_pin;
      rx_s_ff    <= rx_meta_ff;
      rx_prev_ff <= rx_s_ff;
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (start_hdr) begin
          nxt_state = S_BRK;
        end else if (start_sw) begin
          nxt_state = S_BYTE;
        end
      end
      S_BRK: begin
        if (last_bit) begin
          nxt_state = S_DLM;
        end
      end
      S_DLM: begin
        if (last_bit) begin
          nxt_state = (hsel_ff != 2'b00) ? S_BYTE : S_IDLE;
        end
      end
      S_BYTE: begin
        if (last_bit) begin
          nxt_state = S_SPC;
        end
      end
      S_SPC: begin
        if (last_bit) begin
          nxt_state = (hdr_ff & sync_done_ff & hsel_ff == 2'b10) ?
                      S_BYTE : S_IDLE;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // transmit datapath: lengths, shifter, readback capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= S_IDLE;
      cnt_ff       <= 9'd0;
      sh_ff        <= 10'h3ff;
      tx_ff        <= 1'b1;
      hdr_ff       <= 1'b0;
      sync_done_ff <= 1'b0;
      rxsh_ff      <= 10'h000;
    end else begin
      state_ff <= nxt_state;
      if (start_hdr) begin
        hdr_ff       <= 1'b1;
        sync_done_ff <= 1'b0;
        tx_ff        <= 1'b0;
        cnt_ff       <= {5'h00, break_length_ff} + 9'd1;
      end else if (start_sw) begin
        sh_ff  <= {1'b1, hold_ff, 1'b0};
        tx_ff  <= 1'b0;
        cnt_ff <= `BYTE_BITS;
      end else if (tx_tick) begin
        if (state_ff[3]) begin
          rxsh_ff <= {rx_s_ff, rxsh_ff[9:1]};
        end
        if (cnt_ff != 9'd1) begin
          cnt_ff <= cnt_ff - 9'd1;
          if (state_ff[3]) begin
            sh_ff <= {1'b1, sh_ff[9:1]};
            tx_ff <= sh_ff[1];
          end
        end else begin
          case (nxt_state)
            S_DLM: begin
              tx_ff  <= 1'b1;
              cnt_ff <= {7'h00, bsl_ff} + 9'd1;
            end
            S_BYTE: begin
              tx_ff  <= 1'b0;
              cnt_ff <= `BYTE_BITS;
              if (!sync_done_ff) begin
                sh_ff        <= {1'b1, `SYNC_BYTE, 1'b0};
                sync_done_ff <= 1'b1;
              end else begin
                sh_ff        <= {1'b1, id_byte, 1'b0};
                sync_done_ff <= 1'b0;
              end
            end
            S_SPC: begin
              tx_ff  <= 1'b1;
              cnt_ff <= {1'b0, dly_ff} + 9'd1;
            end
            default: begin
              tx_ff  <= 1'b1;
              hdr_ff <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // break detector: counts dominant samples, flags on recessive after >11
  assign lin_set = det_tick & rx_s_ff & (zcnt_ff > `BRK_MIN_BITS);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zcnt_ff <= 4'h0;
    end else if (!brkdet_en_ff) begin
      zcnt_ff <= 4'h0;
    end else if (det_tick) begin
      if (rx_s_ff) begin
        zcnt_ff <= 4'h0;
      end else if (zcnt_ff != 4'hf) begin
        zcnt_ff <= zcnt_ff + 4'h1;
      end
    end
  end

  // compare late in each bit so the bus loop delay has settled
  assign berr_set = tx_tick & ~is_idle & lin_mode & biterr_en_ff
                    & (rx_s_ff != tx_ff);

  // apb slave: no wait states, answer registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & (paddr[7:2] > `OFS_INTCLR);
      if (psel & ~penable & ~pwrite) begin
        case (widx)
          `OFS_DATA:    prdata_ff <= {24'h000000, rx_data_ff};
          `OFS_BAUD:    prdata_ff <= {16'h0000, div_ff};
          `OFS_LINE:    prdata_ff <= {26'h0000000, line_ff};
          `OFS_LINCTL:  prdata_ff <= {pid_ff, hsel_ff, bsl_ff, break_length_ff,
                                      3'h0, biterr_en_ff, 1'b0,
                                      brkdet_en_ff, id_parity_hw_enable_ff, send_ff,
                                      8'h00};
          `OFS_LINSTS:  prdata_ff <= {23'h000000, brk_flag_ff, 8'h00};
          `OFS_FIFOSTS: prdata_ff <= {3'h0, tx_empty, 28'h0000000};
          `OFS_TOUT:    prdata_ff <= {16'h0000, dly_ff, 8'h00};
          `OFS_INTSTS:  prdata_ff <= {16'h0000, rd_ists};
          `OFS_INTEN:   prdata_ff <= {16'h0000, rd_ien};
          default:      prdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // software registers and hardware-set flags; a set beats a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff       <= `BAUD_RST;
      line_ff      <= 6'h00;
      send_ff      <= 1'b0;
      id_parity_hw_enable_ff     <= 1'b0;
      brkdet_en_ff <= 1'b0;
      biterr_en_ff <= 1'b0;
      break_length_ff     <= `BREAK_LENGTH_RST;
      bsl_ff       <= `BSL_RST;
      hsel_ff      <= 2'b00;
      pid_ff       <= 8'h00;
      dly_ff       <= `DLY_RST;
      brk_flag_ff  <= 1'b0;
      ists_ff      <= 3'b000;
      ien_ff       <= 3'b000;
      hold_ff      <= 8'h00;
      hold_vld_ff  <= 1'b0;
      rx_data_ff   <= 8'h00;
      irq_ff       <= 1'b0;
    end else begin
      if (start_sw) begin
        hold_vld_ff <= 1'b0;
      end
      if (wr_en) begin
        case (widx)
          `OFS_DATA: begin
            // a write while the holding byte is occupied is dropped
            if (!hold_vld_ff) begin
              hold_ff     <= pwdata[7:0];
              hold_vld_ff <= 1'b1;
            end
          end
          `OFS_BAUD: div_ff  <= pwdata[15:0];
          `OFS_LINE: line_ff <= pwdata[5:0];
          `OFS_LINCTL: begin
            // parameters are frozen while a header is running
            if (!send_ff) begin
              send_ff  <= pwdata[`CTL_SEND] & lin_mode;
              id_parity_hw_enable_ff <= pwdata[`CTL_ID_PARITY_HW_ENABLE];
              break_length_ff <= pwdata[19:16];
              bsl_ff   <= pwdata[21:20];
              hsel_ff  <= pwdata[23:22];
              pid_ff   <= pwdata[31:24];
            end
            brkdet_en_ff <= pwdata[`CTL_BREAK_DETECT_ENABLE];
            biterr_en_ff <= pwdata[`CTL_BIT_ERROR_MONITOR_ENABLE];
          end
          `OFS_LINSTS: begin
            if (pwdata[`STS_BRKDET]) begin
              brk_flag_ff <= 1'b0;
            end
          end
          `OFS_TOUT:  dly_ff <= pwdata[15:8];
          `OFS_INTEN: ien_ff <= {pwdata[`INT_LIN], pwdata[`INT_BITERR],
                                 pwdata[`INT_RDA]};
          `OFS_INTCLR: ists_ff <= ists_ff & ~{pwdata[`INT_LIN],
                                  pwdata[`INT_BITERR], pwdata[`INT_RDA]};
          default: begin
          end
        endcase
      end
      if (rd_en && widx == `OFS_DATA) begin
        ists_ff[0] <= 1'b0;
      end
      // header done: after delimiter for select 0, else after last space
      if (hdr_ff & last_bit & (state_ff[2] | state_ff[4])
          & (nxt_state == S_IDLE)) begin
        send_ff <= 1'b0;
      end
      if (last_bit & state_ff[3]) begin
        rx_data_ff <= rxsh_ff[9:2];
        ists_ff[0] <= 1'b1;
      end
      if (berr_set) begin
        ists_ff[1] <= 1'b1;
      end
      if (lin_set) begin
        brk_flag_ff <= 1'b1;
        if (ien_ff[2]) begin
          ists_ff[2] <= 1'b1;
        end
      end
      irq_ff <= |(ists_ff & ien_ff);
    end
  end
endmodule
`default_nettype wire

// >>> verif/lin_bus_node.sv
// far side of the lin wire: loopback with a slave able to hold it low
`timescale 1ns/1ps
`default_nettype none
module lin_bus_node (
  input  wire logic tx_pin,
  input  wire logic stuck_low,
  output logic      rx_pin
);
  // wired-and, pull-up makes recessive; a stuck slave wins as dominant
  assign rx_pin = tx_pin & ~stuck_low;
endmodule
`default_nettype wire

// >>> verif/lin_master_chk.sv
// assertion checker for the lin master block
`timescale 1ns/1ps
`default_nettype none
module lin_master_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_pin,
  input wire logic        tx_pin,
  input wire logic        irq
);
  logic [15:0] div_ff;
  logic [19:0] low_ff;
  // divider shadow so the break bound follows the programmed bit time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 16'h0043;
      low_ff <= 20'h0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 8'h04)
        div_ff <= pwdata[15:0];
      low_ff <= tx_pin ? 20'h0 : low_ff + 20'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable && pready; endsequence
  sequence s_rd; psel && penable && pready && !pwrite; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_unmap; s_rd ##0 (paddr[7:2] > 6'd9) |-> pslverr && !prdata;
  endproperty
  property p_map; s_acc ##0 (paddr[7:2] <= 6'd9) |-> !pslverr; endproperty
  property p_mask;
    s_acc ##0 (pwrite && paddr == 8'h20 && pwdata == 32'h0) |=> ##1 !irq;
  endproperty
  property p_empty;
    s_rd ##0 (paddr == 8'h14 && !tx_pin && !$past(tx_pin)) |-> !prdata[28];
  endproperty
  property p_brk; low_ff <= 20'd16 * ({4'h0, div_ff} + 20'd1) + 20'd2;
  endproperty
  property p_rst; disable iff (1'b0) !presetn |-> tx_pin; endproperty
  property p_rel; $rose(presetn) |-> tx_pin ##1 tx_pin; endproperty
  a_ready: assert property (p_ready) else $error("no pready after setup");
  a_pulse: assert property (p_pulse) else $error("pready longer than one");
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  a_map: assert property (p_map) else $error("mapped access refused");
  a_mask: assert property (p_mask) else $error("irq not masked");
  a_empty: assert property (p_empty) else $error("empty while sending");
  a_brk: assert property (p_brk) else $error("dominant run too long");
  a_rst: assert property (p_rst) else $error("tx not idle in reset");
  a_rel: assert property (p_rel) else $error("tx not idle at start");
endmodule
bind lin_master_header_break_detect lin_master_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
  .irq(irq));
`default_nettype wire

// >>> verif/lin_master_header_break_detect_tb.sv
// self-checking bench for the lin master block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, x); end end
module lin_master_header_break_detect_tb;
  logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
  logic        stuck_low = 0;
  logic [7:0]  paddr = 8'h00, d;
  logic [31:0] pwdata = 32'h0, rd_q, e, m;
  logic [31:0] exp_q[$], msk_q[$];
  logic [1:0]  tx_q[$], b;
  wire  [31:0] prdata;
  wire         pready, pslverr, rx_pin, tx_pin, irq;
  int          mismatches = 0, comparisons = 0, bt = 8;
  initial forever #4 pclk = ~pclk;
  lin_master_header_break_detect dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
  lin_bus_node node (.tx_pin(tx_pin), .stuck_low(stuck_low), .rx_pin(rx_pin));
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] x);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= x;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
    exp_q.push_back(x); msk_q.push_back(k); apb(0, a, 32'h0);
  endtask
  task wait_bit(input logic [7:0] a, input int n, input logic v);
    do rd(a, 32'h0, 32'h0); while (rd_q[n] !== v);
  endtask
  task exp_n(input logic v, input int n);
    repeat (n) tx_q.push_back({1'b0, v});
  endtask
  task exp_byte(input logic [7:0] v, input int sp);
    exp_n(0, 1); for (int i = 0; i < 8; i++) exp_n(v[i], 1); exp_n(1, sp + 2);
  endtask
  function logic [7:0] id_of(input logic [7:0] p, input logic en);
    id_of = en ? {~(p[1]^p[3]^p[4]^p[5]), p[0]^p[1]^p[2]^p[4], p[5:0]} : p;
  endfunction
  task header(input logic [1:0] sel, input logic [3:0] brk,
              input logic [1:0] delimiter_length, input logic [7:0] dly, input logic en);
    logic [7:0] protected_identifier, id;
    protected_identifier = 8'($urandom());
    id = id_of(protected_identifier, en);
    apb(1, 8'h18, {16'h0, dly, 8'h0}); apb(1, 8'h24, '1); apb(1, 8'h10, '1);
    tx_q.push_back(2'd2); exp_n(0, brk + 1); exp_n(1, delimiter_length + 1);
    if (sel != 0) exp_byte(8'h55, dly);
    if (sel == 2) exp_byte(id, dly);
    apb(1, 8'h0c, {protected_identifier, sel, delimiter_length, brk, 5'h02, 1'b1, en, 1'b1, 8'h0});
    wait_bit(8'h0c, 8, 0);
    if (sel == 0) begin
      wait_bit(8'h10, 8, 1);
      tx_q.push_back(2'd2); exp_byte(8'h55, dly); apb(1, 8'h00, 32'h55);
      wait_bit(8'h1c, 0, 1); rd(8'h00, 32'h55, 32'hff);
    end
    if (sel != 2) begin
      tx_q.push_back(2'd2); exp_byte(id, dly); apb(1, 8'h00, {24'h0, id});
    end
    wait_bit(8'h14, 28, 1);
    rd(8'h00, {24'h0, id}, 32'hff);
    rd(8'h10, {23'h0, brk >= 4'hb, 8'h0}, 32'h100);
    rd(8'h1c, {16'h0, brk >= 4'hb, 15'h0}, 32'h8003);
    $display("test header sel %0d done", sel);
  endtask
  // only noted reads with a mask count as comparisons; polls pass through
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size()) begin
      e = exp_q.pop_front(); m = msk_q.pop_front();
      if (m != 0) `CHK(prdata & m, e)
    end
  // marker 2 realigns on the next start edge, then samples mid-bit
  initial forever begin
    wait (tx_q.size() > 0);
    b = tx_q.pop_front();
    if (b == 2'd2) begin
      @(negedge tx_pin);
      repeat (bt / 2) @(posedge pclk);
    end else begin
      `CHK(tx_pin, b[0])
      if (tx_q.size() > 0 && tx_q[0] != 2'd2) repeat (bt) @(posedge pclk);
    end
  end
  initial begin
    presetn <= 1'b0;
    void'($urandom(61));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h04, 32'h43, '1); rd(8'h0c, 32'h000b0000, '1);
    rd(8'h18, 32'h0, '1); rd(8'h14, 32'h10000000, 32'h10000000);
    rd(8'h28, 32'h0, '1);
    bt = 8 + $urandom_range(3);
    apb(1, 8'h04, bt - 1); apb(1, 8'h08, 32'h13);
    apb(1, 8'h20, 32'h8003);
    $display("test reset values done");
    header(2, 4'hb, 0, 0, 1); header(2, 4'hf, 2, 3, 0);
    header(1, 4'h9, 1, 1, 1); header(0, 4'hb, 0, 2, 0);
    apb(1, 8'h18, 32'h0); apb(1, 8'h24, '1); apb(1, 8'h10, '1);
    d = 8'($urandom());
    tx_q.push_back(2'd2); exp_byte(d, 0);
    stuck_low <= 1'b1;
    apb(1, 8'h00, {24'h0, d});
    wait_bit(8'h14, 28, 1);
    repeat (3 * bt) @(posedge pclk);
    `CHK(irq, 1'b1)
    rd(8'h1c, 32'h2, 32'h2);
    stuck_low <= 1'b0;
    repeat (3 * bt) @(posedge pclk);
    rd(8'h10, 32'h100, 32'h100); rd(8'h00, 32'h0, 32'hff);
    apb(1, 8'h20, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1, 8'h24, '1); rd(8'h1c, 32'h0, 32'h8003);
    $display("test bit error and far break done");
    complete_run;
  end
  initial begin
    #400000;
    mismatches++;
    complete_run;
  end
endmodule
`default_nettype wire
